// file: tpc_map.vh
`ifndef TPC_MAP_VH
`define TPC_MAP_VH

// Host-side timing, in ns, at a 100 ns core clock
`define TPC_CLK_PERIOD_NS   100
`define TPC_HOLD_NS         100
`define TPC_BUS_SETTLE_NS   100
`define TPC_HOLD_CYC        ((`TPC_HOLD_NS + `TPC_CLK_PERIOD_NS - 1) / `TPC_CLK_PERIOD_NS)
`define TPC_SETTLE_CYC      ((`TPC_BUS_SETTLE_NS + `TPC_CLK_PERIOD_NS - 1) / `TPC_CLK_PERIOD_NS)

// Resolution select codes
`define TPC_RES_10          2'h0
`define TPC_RES_12          2'h1
`define TPC_RES_14          2'h2
`define TPC_RES_16          2'h3

// Counter bits to keep for each resolution
`define TPC_MASK_10         16'h03FF
`define TPC_MASK_12         16'h0FFF
`define TPC_MASK_14         16'h3FFF
`define TPC_MASK_16         16'hFFFF

// Step rate ceiling, Hz
`define TPC_MAX_STEP_HZ     1100000

`endif

// file: tpc_host_ctrl.v
`timescale 1ns/1ns
// Behaviour
// R1: Direction changes before busy, data, carry
// R2: Direction output may toggle asynchronously
// R3: Clear input active low, idles high
// R4: Load plus clear clears bits set
// R5: Load alone presets counter from data
// R6: Tri-state outputs before driving preset word
// R7: Hold strobes and data 100 ns
// R8: Release data, enable outputs, then read
// R9: Steps only at one LSB error
// R10: Count direction follows oscillator polarity
// R11: Oscillator has 40 ns reset interval
// R12: Keep step rate at most 1.1 MHz
// R13: Steps per revolution by resolution
// R14: Control-transformer use presets held angle
// R15: One busy pulse per counter step
// R16: Enable high tri-states data pins; the device model drives the inverted counter instead
// R17: Carry edge on all-ones/zeros wrap
// R18: Unused data lines read low
// R19: Counter wraps modulo revolution count

`include "tpc_map.vh"

module tpc_host_ctrl #(
  parameter WIDTH = 16
) (
  input  wire             core_clk_i,
  input  wire             rst_b_i,
  input  wire             cmd_load_i,
  input  wire             cmd_clear_i,
  input  wire             cmd_read_i,
  input  wire [WIDTH-1:0] cmd_data_i,
  input  wire [1:0]       cmd_res_i,
  output wire             cmd_ready_o,
  output reg              rd_valid_o,
  output reg  [WIDTH-1:0] rd_data_o,
  input  wire [WIDTH-1:0] dev_data_i,
  output reg  [WIDTH-1:0] dev_data_o,
  output reg              dev_data_oe_o,
  output reg              dev_load_b_o,
  output reg              dev_clear_b_o,
  output reg              dev_enable_b_o
);

  // Sequencer states: a preset runs TRI to READ, a plain readback only ENABLE and READ
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_TRI    = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_HOLD   = 3'h3;
  localparam [2:0] ST_FREE   = 3'h4;
  localparam [2:0] ST_ENABLE = 3'h5;
  localparam [2:0] ST_READ   = 3'h6;

  // Whole-cycle waits, rounded up from the nanosecond figures, cut to the counter width
  localparam integer HOLD_CYC_INT   = `TPC_HOLD_CYC;
  localparam integer SETTLE_CYC_INT = `TPC_SETTLE_CYC;
  localparam [3:0]   HOLD_CYC       = HOLD_CYC_INT[3:0];
  localparam [3:0]   SETTLE_CYC     = SETTLE_CYC_INT[3:0];

  // Sequencer, wait counter and the request captured in idle
  reg [2:0]       state_reg;
  reg [2:0]       state_next;
  reg [3:0]       cnt_reg;
  reg [3:0]       cnt_next;
  reg             clr_reg;
  reg [1:0]       res_reg;
  reg [WIDTH-1:0] word_reg;

  // Keep only the bits the selected resolution uses
  function [WIDTH-1:0] res_mask;
    input [1:0] res;
    begin
      case (res)
        `TPC_RES_10: res_mask = `TPC_MASK_10;
        `TPC_RES_12: res_mask = `TPC_MASK_12;
        `TPC_RES_14: res_mask = `TPC_MASK_14;
        default:     res_mask = `TPC_MASK_16;
      endcase
    end
  endfunction

  // Wait counter helpers, shared by the three timed states
  function wait_over;
    input [3:0] cnt;
    begin
      wait_over = (cnt <= 4'h1);
    end
  endfunction

  function [3:0] count_down;
    input [3:0] cnt;
    begin
      count_down = cnt - 4'h1;
    end
  endfunction

  // Requests are taken only in idle; anything raised meanwhile is simply ignored
  assign cmd_ready_o = (state_reg == ST_IDLE);

  // Sequencer next state; all waits counted in whole cycles
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      // Clear wins over load: it needs the load strobe in any case
      ST_IDLE: begin
        if (cmd_load_i || cmd_clear_i) begin
          state_next = ST_TRI; // R6
          cnt_next   = SETTLE_CYC;
        end else if (cmd_read_i) begin
          state_next = ST_ENABLE;
          cnt_next   = SETTLE_CYC;
        end
      end
      // Word settles on the pins before any strobe falls
      ST_TRI: begin
        if (wait_over(cnt_reg)) begin
          state_next = ST_STROBE;
        end else begin
          cnt_next = count_down(cnt_reg);
        end
      end
      ST_STROBE: begin
        state_next = ST_HOLD;
        cnt_next   = HOLD_CYC;
      end
      // Strobe stays low for STROBE plus HOLD, so never shorter than the hold time
      ST_HOLD: begin
        if (wait_over(cnt_reg)) begin
          state_next = ST_FREE; // R7
        end else begin
          cnt_next = count_down(cnt_reg);
        end
      end
      // Data leaves the pins before the device outputs come back on
      ST_FREE: begin
        state_next = ST_ENABLE; // R8
        cnt_next   = SETTLE_CYC;
      end
      // Device drives the pins; give its outputs time before sampling
      ST_ENABLE: begin
        if (wait_over(cnt_reg)) begin
          state_next = ST_READ;
        end else begin
          cnt_next = count_down(cnt_reg);
        end
      end
      // One cycle to hand the word over, then back to idle
      ST_READ: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State, captured command and pin registers
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      // Pins released: no strobe, host off the bus, device outputs tri-stated
      state_reg      <= ST_IDLE;
      cnt_reg        <= 4'h0;
      clr_reg        <= 1'b0;
      res_reg        <= `TPC_RES_16;
      word_reg       <= {WIDTH{1'b0}};
      rd_valid_o     <= 1'b0;
      rd_data_o      <= {WIDTH{1'b0}};
      dev_data_o     <= {WIDTH{1'b0}};
      dev_data_oe_o  <= 1'b0;
      dev_load_b_o   <= 1'b1;
      dev_clear_b_o  <= 1'b1; // R3
      dev_enable_b_o <= 1'b1; // R16
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      rd_valid_o <= 1'b0;
      if (state_reg == ST_IDLE) begin
        res_reg <= cmd_res_i;
        if (cmd_load_i || cmd_clear_i) begin
          clr_reg  <= cmd_clear_i;
          // Preset word limited to the counter span
          word_reg <= cmd_data_i & res_mask(cmd_res_i); // R13
        end
      end
      case (state_next)
        ST_TRI: begin
          dev_enable_b_o <= 1'b1; // R6
          dev_data_oe_o  <= 1'b1;
          dev_data_o     <= word_reg;
        end
        // Clear only rides on the load strobe; on its own it would do nothing
        ST_STROBE: begin
          dev_load_b_o  <= 1'b0; // R5
          dev_clear_b_o <= ~clr_reg; // R4
        end
        ST_FREE: begin
          // Data withdrawn only after the hold, strobes with it
          dev_data_oe_o <= 1'b0; // R7
          dev_load_b_o  <= 1'b1;
          dev_clear_b_o <= 1'b1;
        end
        ST_ENABLE: begin
          dev_enable_b_o <= 1'b0; // R8
        end
        // Outputs back to tri-state as soon as the word is taken
        ST_READ: begin
          dev_enable_b_o <= 1'b1;
        end
        default: begin
        end
      endcase
      // Word goes out straight from the request, as word_reg is not yet loaded
      if (state_next == ST_TRI && state_reg == ST_IDLE) begin
        dev_data_o <= cmd_data_i & res_mask(cmd_res_i); // R14
      end
      // Sample bus while enable is still low; high bits masked
      if (state_reg == ST_ENABLE && state_next == ST_READ) begin
        rd_valid_o <= 1'b1;
        rd_data_o  <= dev_data_i & res_mask(res_reg); // R18
      end
    end
  end

endmodule // tpc_host_ctrl

// file: tpc_dev_model.sv
`timescale 1ns/1ns
// Device stand-in: counter, preset, selective clear, stepping, enable-gated data pins
module tpc_dev_model (
  input  wire        clk_i,
  input  wire [15:0] data_i,
  input  wire        load_b_i,
  input  wire        clear_b_i,
  input  wire        enable_b_i,
  input  wire [1:0]  res_i,
  input  wire        step_i,
  input  wire        up_i,
  output wire [15:0] data_o,
  output wire        dir_o,
  output reg         busy_o,
  output reg         carry_o
);
  reg  [15:0] cnt_reg;
  wire [15:0] mask = 16'hFFFF >> (4'h6 - {res_i, 1'b0});
  wire        wrap = up_i ? (cnt_reg == mask) : (cnt_reg == 16'h0000);
  // Preset wins over stepping; step_i marks an error of one LSB or more
  // At most one step per clock: the 40 ns oscillator reset is shorter than a clock
  always @(posedge clk_i) begin
    busy_o  <= 1'b0;
    carry_o <= 1'b0;
    if (!load_b_i)
      cnt_reg <= (clear_b_i ? data_i : cnt_reg & ~data_i) & mask;
    else if (step_i) begin
      cnt_reg <= (up_i ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001) & mask;
      busy_o  <= 1'b1;
      carry_o <= wrap;
    end
  end
  // Sense follows the oscillator polarity at once, ahead of busy, data and carry
  assign dir_o = up_i;
  // Released pins show the inverted counter instead of going high impedance
  assign data_o = enable_b_i ? ~cnt_reg : cnt_reg & mask;
endmodule // tpc_dev_model

// file: tpc_host_ctrl_monitor.sv
`timescale 1ns/1ns
module tpc_host_ctrl_monitor #(
  parameter WIDTH = 16
) (
  input wire             core_clk_i,
  input wire             rst_b_i,
  input wire             cmd_load_i,
  input wire             cmd_clear_i,
  input wire             cmd_read_i,
  input wire [WIDTH-1:0] cmd_data_i,
  input wire [1:0]       cmd_res_i,
  input wire             cmd_ready_o,
  input wire             rd_valid_o,
  input wire [WIDTH-1:0] rd_data_o,
  input wire [WIDTH-1:0] dev_data_i,
  input wire [WIDTH-1:0] dev_data_o,
  input wire             dev_data_oe_o,
  input wire             dev_load_b_o,
  input wire             dev_clear_b_o,
  input wire             dev_enable_b_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Resolution that goes with the request in flight, taken while idle
  reg [1:0] res_taken;
  always @(posedge core_clk_i) begin
    if (cmd_ready_o) res_taken <= cmd_res_i;
  end
  load_on_bus_a: assert property (!dev_load_b_o |-> dev_data_oe_o && dev_enable_b_o)
    else $error("load strobe without bus");
  strobe_hold_a: assert property ($fell(dev_load_b_o) |=> !dev_load_b_o && $stable(dev_data_o))
    else $error("strobe hold short");
  read_after_release_a: assert property (!dev_enable_b_o |-> !dev_data_oe_o && dev_load_b_o)
    else $error("enable while driving");
  clear_with_load_a: assert property (!dev_clear_b_o |-> !dev_load_b_o)
    else $error("clear without load");
  load_answer_a: assert property (cmd_ready_o && (cmd_load_i || cmd_clear_i) |-> ##6 rd_valid_o)
    else $error("load answer late");
  read_answer_a: assert property (cmd_ready_o && cmd_read_i && !cmd_load_i && !cmd_clear_i |-> ##2 rd_valid_o)
    else $error("read answer late");
  read_enabled_a: assert property (rd_valid_o |-> !$past(dev_enable_b_o))
    else $error("read while disabled");
  upper_bits_low_a: assert property (rd_valid_o && res_taken == 2'h0 |-> rd_data_o[15:10] == 6'h00)
    else $error("unused bits set");
  cover property ($fell(dev_clear_b_o));
  cover property ($fell(dev_load_b_o) && dev_clear_b_o);
  cover property (rd_valid_o);
endmodule // tpc_host_ctrl_monitor
bind tpc_host_ctrl tpc_host_ctrl_monitor #(.WIDTH(WIDTH)) u_mon (
  .core_clk_i    (core_clk_i),
  .rst_b_i       (rst_b_i),
  .cmd_load_i    (cmd_load_i),
  .cmd_clear_i   (cmd_clear_i),
  .cmd_read_i    (cmd_read_i),
  .cmd_data_i    (cmd_data_i),
  .cmd_res_i     (cmd_res_i),
  .cmd_ready_o   (cmd_ready_o),
  .rd_valid_o    (rd_valid_o),
  .rd_data_o     (rd_data_o),
  .dev_data_i    (dev_data_i),
  .dev_data_o    (dev_data_o),
  .dev_data_oe_o (dev_data_oe_o),
  .dev_load_b_o  (dev_load_b_o),
  .dev_clear_b_o (dev_clear_b_o),
  .dev_enable_b_o(dev_enable_b_o)
);

// file: tb_tracking_position_counter.sv
`timescale 1ns/1ns
`define CHK(a,b) begin comparisons++; if ((a) !== (b)) begin failures++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_tracking_position_counter;
  reg core_clk_i = 0, rst_b_i = 0, ld = 0, cl = 0, rd = 0, step = 0, up = 0;
  reg [15:0] wd = 16'h0000;
  reg [1:0] res = 2'h3;
  wire rdy, vld, oe, lb, cb, eb;
  wire dir, busy, carry;
  wire [15:0] rdat, hd, dd;
  integer failures = 0, comparisons = 0, cyc = 0, k, busy_cnt = 0;
  // 1.1 MHz step ceiling: steps at least ten core clocks apart
  localparam integer STEP_GAP = 10;
  always #50 core_clk_i = ~core_clk_i;
  tpc_host_ctrl u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cmd_load_i(ld), .cmd_clear_i(cl),
    .cmd_read_i(rd), .cmd_data_i(wd), .cmd_res_i(res), .cmd_ready_o(rdy), .rd_valid_o(vld), .rd_data_o(rdat),
    .dev_data_i(dd), .dev_data_o(hd), .dev_data_oe_o(oe), .dev_load_b_o(lb), .dev_clear_b_o(cb), .dev_enable_b_o(eb));
  tpc_dev_model u_dev (.clk_i(core_clk_i), .data_i(hd), .load_b_i(lb), .clear_b_i(cb), .enable_b_i(eb),
    .res_i(res), .step_i(step), .up_i(up), .data_o(dd), .dir_o(dir), .busy_o(busy), .carry_o(carry));
  task conclude;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // One request, bounded wait for its answer, then compare readback
  task op(input l, input c, input r, input [15:0] d, input [15:0] e);
    begin
      @(posedge core_clk_i); #1; ld = l; cl = c; rd = r; wd = d;
      @(posedge core_clk_i); #1; ld = 0; cl = 0; rd = 0;
      k = 0;
      while (vld !== 1'b1 && k < 20) begin @(posedge core_clk_i); #1; k = k + 1; end
      if (k >= 20) failures++;
      `CHK(rdat, e)
      $display("test done %h", e);
    end
  endtask
  // One counter step from the oscillator side
  task pulse(input u);
    begin
      repeat (STEP_GAP) @(posedge core_clk_i);
      #1; step = 1; up = u;
      @(posedge core_clk_i); #1; step = 0;
    end
  endtask
  // Busy pulses seen by the host side, one expected per step
  always @(posedge core_clk_i) if (busy === 1'b1) busy_cnt = busy_cnt + 1;
  // Run ceiling, far above the fewer than a hundred cycles the tests need
  always @(posedge core_clk_i) begin cyc = cyc + 1; if (cyc > 3000) begin failures++; conclude; end end
  initial begin
    repeat (8) @(posedge core_clk_i);
    #1 rst_b_i = 1;
    op(1, 0, 0, 16'hA5C3, 16'hA5C3);
    op(0, 1, 0, 16'h0F00, 16'hA0C3);
    op(1, 1, 0, 16'h00C0, 16'hA003);
    op(0, 0, 1, 16'h0000, 16'hA003);
    op(1, 0, 0, 16'hFFFF, 16'hFFFF);
    pulse(1);
    `CHK(carry, 1'b1)
    op(0, 0, 1, 16'h0000, 16'h0000);
    pulse(0);
    `CHK(carry, 1'b1)
    `CHK(dir, 1'b0)
    op(0, 0, 1, 16'h0000, 16'hFFFF);
    res = 2'h0;
    op(1, 0, 0, 16'hFFFF, 16'h03FF);
    pulse(1);
    `CHK(carry, 1'b1)
    op(0, 0, 1, 16'h0000, 16'h0000);
    `CHK(busy_cnt, 3)
    conclude;
  end
endmodule // tb_tracking_position_counter
